/* hdl/udc_pkg.sv */
// constants for the usb descriptor configuration block
package udc_pkg;
    // ****************************************************
    // register port widths
    // ****************************************************
    localparam int AW = 12;
    localparam int DW = 24;
    // ****************************************************
    // register offsets
    // ****************************************************
    localparam logic [AW-1:0] OFF_SPEC = 12'h2bc;
    localparam logic [AW-1:0] OFF_VID = 12'h2be;
    localparam logic [AW-1:0] OFF_PID = 12'h2bf;
    localparam logic [AW-1:0] OFF_S_MAKER = 12'h2c0;
    localparam logic [AW-1:0] OFF_S_PROD = 12'h2c2;
    localparam logic [AW-1:0] OFF_S_SERIAL = 12'h2c3;
    localparam logic [AW-1:0] OFF_S_CFG = 12'h2c4;
    localparam logic [AW-1:0] OFF_ATTR = 12'h2c5;
    localparam logic [AW-1:0] OFF_IF0 = 12'h2c7;
    localparam logic [AW-1:0] OFF_LANG = 12'h2c9;
    localparam logic [AW-1:0] OFF_IF1 = 12'h2d4;
    localparam logic [AW-1:0] OFF_EP0 = 12'h2d8;
    localparam logic [AW-1:0] OFF_PWR = 12'h3f2;
    localparam logic [AW-1:0] OFF_WAKE = 12'h3f3;
    localparam logic [AW-1:0] OFF_CTRL = 12'h400;
    localparam logic [AW-1:0] OFF_STAT = 12'h401;
    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [15:0] RST_SPEC = 16'h0110;
    localparam logic [15:0] RST_VID = 16'hf0e1; // arbitrary value
    localparam logic [15:0] RST_PID = 16'h5a3c; // arbitrary value
    localparam logic [15:0] RST_STR = 16'h0000; // index zero: absent
    localparam logic [15:0] RST_ATTR = 16'h00c0;
    localparam logic [23:0] RST_IFC = 24'he00101;
    localparam logic [15:0] RST_LANG = 16'h0409;
    localparam logic [15:0] RST_EP0 = 16'h0040;
    // ****************************************************
    // attribute field layout
    // ****************************************************
    localparam int ATTR_RSVD1 = 7;
    localparam int ATTR_SELF = 6;
    localparam int ATTR_WAKE = 5;
    // ****************************************************
    // endpoints, transfer types, requests
    // ****************************************************
    localparam logic [3:0] EP_CTRL = 4'h0;
    localparam logic [3:0] EP_EVT = 4'h1;
    localparam logic [3:0] EP_ACL = 4'h2;
    localparam logic [3:0] EP_SCO = 4'h3;
    localparam logic [1:0] XT_CTRL = 2'h0;
    localparam logic [1:0] XT_ISO = 2'h1;
    localparam logic [1:0] XT_BULK = 2'h2;
    localparam logic [1:0] XT_INTR = 2'h3;
    localparam logic [7:0] RQ_SET_ADDR = 8'h05;
    localparam logic [7:0] RQ_SET_CFG = 8'h09;
    // device states, gray along detach-attach-default-address-configure
    typedef enum logic [2:0] {
        ST_DETACHED = 3'h0,
        ST_ATTACHED = 3'h1,
        ST_DEFAULT = 3'h3,
        ST_ADDRESSED = 3'h2,
        ST_CONFIGURED = 3'h6
    } udc_dev_e;
endpackage

/* hdl/udc_desc_core.sv */
// usb attach, addressing, endpoint map and descriptor key store
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module udc_desc_core
    import udc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // usb line and bus reset
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic usb_bus_reset,
    output logic dp_pullup_en,
    // setup requests from the serial engine
    input wire logic req_valid,
    input wire logic [7:0] req_type,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_value,
    input wire logic [15:0] req_index,
    input wire logic req_status_done,
    output logic req_std,
    output logic req_hci_cmd,
    output logic req_stall,
    // token routing
    input wire logic tok_valid,
    input wire logic [6:0] tok_addr,
    input wire logic [3:0] tok_ep,
    output logic tok_hit,
    output logic [1:0] tok_xfer,
    output logic tok_iface,
    output logic tok_retry_ok,
    // device state
    output logic [6:0] dev_addr,
    output logic [2:0] dev_state,
    // descriptor fields
    output logic [15:0] desc_bcd_usb,
    output logic [15:0] desc_vendor,
    output logic [15:0] desc_product,
    output logic [7:0] desc_i_maker,
    output logic [7:0] desc_i_product,
    output logic [7:0] desc_i_serial,
    output logic [7:0] desc_i_config,
    output logic [7:0] desc_attributes,
    output logic [23:0] desc_if0_class,
    output logic [23:0] desc_if1_class,
    output logic [15:0] desc_lang_id,
    output logic [7:0] desc_ep0_size
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [15:0] spec;
        logic [15:0] vid;
        logic [15:0] pid;
        logic [15:0] s_maker;
        logic [15:0] s_prod;
        logic [15:0] s_serial;
        logic [15:0] s_cfg;
        logic [7:0] attr;
        logic [23:0] if0;
        logic [23:0] if1;
        logic [15:0] lang;
        logic [15:0] ep0;
        logic [7:0] ep0_eff;
        logic connect;
        udc_dev_e st;
        logic [6:0] addr;
        logic [6:0] pend_addr;
        logic pend;
        logic [7:0] cfg;
        logic [DW-1:0] rdata;
        logic req_std;
        logic req_cmd;
        logic req_stall;
        logic tok_hit;
        logic [1:0] tok_xfer;
        logic tok_iface;
        logic tok_retry;
    } udc_state_s;

    udc_state_s q_r;
    udc_state_s q_nxt;

    // ****************************************************
    // helpers
    // ****************************************************

    // clean attributes: reserved bit7 one, bits 4..0 zero
    function automatic logic [7:0] attr_clean(input logic [7:0] a);
        attr_clean = {1'b1, a[ATTR_SELF], a[ATTR_WAKE], 5'h00};
    endfunction

    // packet size check with fallback to 64
    function automatic logic [7:0] ep0_check(input logic [15:0] v);
        case (v)
            16'h0008, 16'h0010, 16'h0020, 16'h0040: begin
                ep0_check = v[7:0];
            end
            default: begin
                ep0_check = RST_EP0[7:0];
            end
        endcase
    endfunction

    // register read mux
    function automatic logic [DW-1:0] rd_mux(input udc_state_s s,
                                             input logic [AW-1:0] a,
                                             input logic dp,
                                             input logic dm);
        rd_mux = '0;
        case (a)
            OFF_SPEC: rd_mux = {8'h00, s.spec};
            OFF_VID: rd_mux = {8'h00, s.vid};
            OFF_PID: rd_mux = {8'h00, s.pid};
            OFF_S_MAKER: rd_mux = {8'h00, s.s_maker};
            OFF_S_PROD: rd_mux = {8'h00, s.s_prod};
            OFF_S_SERIAL: rd_mux = {8'h00, s.s_serial};
            OFF_S_CFG: rd_mux = {8'h00, s.s_cfg};
            OFF_ATTR: rd_mux = {16'h0000, s.attr};
            OFF_IF0: rd_mux = s.if0;
            OFF_LANG: rd_mux = {8'h00, s.lang};
            OFF_IF1: rd_mux = s.if1;
            OFF_EP0: rd_mux = {8'h00, s.ep0};
            OFF_PWR: rd_mux = {23'h000000, s.attr[ATTR_SELF]};
            OFF_WAKE: rd_mux = {23'h000000, s.attr[ATTR_WAKE]};
            OFF_CTRL: rd_mux = {23'h000000, s.connect};
            OFF_STAT: rd_mux = {11'h000, s.cfg[0], dm, dp, s.addr, s.st};
            default: rd_mux = '0;
        endcase
    endfunction

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic ep_ok;
        logic cfg_ok;
        ep_ok = 1'b0;
        cfg_ok = 1'b0;
        q_nxt = q_r;
        q_nxt.req_std = 1'b0;
        q_nxt.req_cmd = 1'b0;
        q_nxt.req_stall = 1'b0;
        q_nxt.tok_hit = 1'b0;
        q_nxt.rdata = '0;

        // register reads: data in the next cycle only
        if (reg_rd) begin
            q_nxt.rdata = rd_mux(q_r, reg_addr, line_dp, line_dm);
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                OFF_SPEC: q_nxt.spec = reg_wdata[15:0];
                OFF_VID: q_nxt.vid = reg_wdata[15:0];
                OFF_PID: q_nxt.pid = reg_wdata[15:0];
                OFF_S_MAKER: q_nxt.s_maker = reg_wdata[15:0];
                OFF_S_PROD: q_nxt.s_prod = reg_wdata[15:0];
                OFF_S_SERIAL: q_nxt.s_serial = reg_wdata[15:0];
                OFF_S_CFG: q_nxt.s_cfg = reg_wdata[15:0];
                OFF_ATTR: q_nxt.attr = attr_clean(reg_wdata[7:0]);
                OFF_IF0: q_nxt.if0 = reg_wdata;
                OFF_LANG: q_nxt.lang = reg_wdata[15:0];
                OFF_IF1: q_nxt.if1 = reg_wdata;
                OFF_EP0: begin
                    q_nxt.ep0 = reg_wdata[15:0];
                    q_nxt.ep0_eff = ep0_check(reg_wdata[15:0]);
                end
                OFF_PWR: q_nxt.attr[ATTR_SELF] = reg_wdata[0];
                OFF_WAKE: q_nxt.attr[ATTR_WAKE] = reg_wdata[0];
                OFF_CTRL: q_nxt.connect = reg_wdata[0];
                default: begin
                end
            endcase
        end

        // new address takes effect after the status stage; a request below wins
        if (req_status_done && q_r.pend) begin
            q_nxt.pend = 1'b0;
            q_nxt.addr = q_r.pend_addr;
            if (q_r.st == ST_DEFAULT && q_r.pend_addr != 7'h00) begin
                q_nxt.st = ST_ADDRESSED;
            end else if (q_r.st == ST_ADDRESSED && q_r.pend_addr == 7'h00) begin
                q_nxt.st = ST_DEFAULT;
            end
        end

        // setup request classification, one shared control pipe
        if (req_valid && q_r.st != ST_DETACHED && q_r.st != ST_ATTACHED) begin
            if (req_type[6:5] == 2'h0) begin
                q_nxt.req_std = 1'b1;
                if (req_code == RQ_SET_ADDR && req_type[4:0] == 5'h00) begin
                    q_nxt.pend_addr = req_value[6:0];
                    q_nxt.pend = 1'b1;
                end
                cfg_ok = q_r.st == ST_ADDRESSED || q_r.st == ST_CONFIGURED;
                if (req_code == RQ_SET_CFG && cfg_ok) begin
                    q_nxt.cfg = req_value[7:0];
                    q_nxt.st = (req_value[7:0] == 8'h00) ? ST_ADDRESSED
                                                          : ST_CONFIGURED;
                end
            end else if (req_type[6:5] == 2'h1 && req_index[7:0] == 8'h00) begin
                q_nxt.req_cmd = 1'b1;
            end else begin
                q_nxt.req_stall = 1'b1;
            end
        end

        // token routing by endpoint
        case (tok_ep)
            EP_CTRL: begin
                q_nxt.tok_xfer = XT_CTRL;
                q_nxt.tok_iface = 1'b0;
                ep_ok = 1'b1;
            end
            EP_EVT: begin
                q_nxt.tok_xfer = XT_INTR;
                q_nxt.tok_iface = 1'b0;
                ep_ok = q_r.st == ST_CONFIGURED;
            end
            EP_ACL: begin
                q_nxt.tok_xfer = XT_BULK;
                q_nxt.tok_iface = 1'b0;
                ep_ok = q_r.st == ST_CONFIGURED;
            end
            EP_SCO: begin
                q_nxt.tok_xfer = XT_ISO;
                q_nxt.tok_iface = 1'b1;
                ep_ok = q_r.st == ST_CONFIGURED;
            end
            default: begin
                ep_ok = 1'b0;
            end
        endcase
        q_nxt.tok_retry = q_nxt.tok_xfer != XT_ISO;
        if (tok_valid && ep_ok && tok_addr == q_r.addr) begin
            if (q_r.st != ST_DETACHED && q_r.st != ST_ATTACHED) begin
                q_nxt.tok_hit = 1'b1;
            end
        end

        // attach and bus reset
        if (q_r.st == ST_DETACHED && q_nxt.connect) begin
            q_nxt.st = ST_ATTACHED;
        end
        if (usb_bus_reset && q_r.st != ST_DETACHED) begin
            q_nxt.st = ST_DEFAULT;
            q_nxt.addr = 7'h00;
            q_nxt.pend = 1'b0;
            q_nxt.cfg = 8'h00;
        end
        if (!q_nxt.connect) begin
            q_nxt.st = ST_DETACHED;
            q_nxt.addr = 7'h00;
            q_nxt.pend = 1'b0;
            q_nxt.cfg = 8'h00;
            q_nxt.tok_hit = 1'b0;
            q_nxt.req_std = 1'b0;
            q_nxt.req_cmd = 1'b0;
            q_nxt.req_stall = 1'b0;
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_r <= '0;
            q_r.spec <= RST_SPEC;
            q_r.vid <= RST_VID;
            q_r.pid <= RST_PID;
            q_r.s_maker <= RST_STR;
            q_r.s_prod <= RST_STR;
            q_r.s_serial <= RST_STR;
            q_r.s_cfg <= RST_STR;
            q_r.attr <= RST_ATTR[7:0];
            q_r.if0 <= RST_IFC;
            q_r.if1 <= RST_IFC;
            q_r.lang <= RST_LANG;
            q_r.ep0 <= RST_EP0;
            q_r.ep0_eff <= RST_EP0[7:0];
            q_r.st <= ST_DETACHED;
            q_r.tok_retry <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************

    // pull-up gives idle J while not detached
    assign dp_pullup_en = q_r.st != ST_DETACHED;

    // register and request answers
    assign reg_rdata = q_r.rdata;
    assign req_std = q_r.req_std;
    assign req_hci_cmd = q_r.req_cmd;
    assign req_stall = q_r.req_stall;

    // token answers
    assign tok_hit = q_r.tok_hit;
    assign tok_xfer = q_r.tok_xfer;
    assign tok_iface = q_r.tok_iface;
    assign tok_retry_ok = q_r.tok_retry;

    // device state
    assign dev_addr = q_r.addr;
    assign dev_state = q_r.st;

    // descriptor fields straight from the key store
    assign desc_bcd_usb = q_r.spec;
    assign desc_vendor = q_r.vid;
    assign desc_product = q_r.pid;
    assign desc_i_maker = q_r.s_maker[7:0];
    assign desc_i_product = q_r.s_prod[7:0];
    assign desc_i_serial = q_r.s_serial[7:0];
    assign desc_i_config = q_r.s_cfg[7:0];
    assign desc_attributes = q_r.attr;
    assign desc_if0_class = q_r.if0;
    assign desc_if1_class = q_r.if1;
    assign desc_lang_id = q_r.lang;
    assign desc_ep0_size = q_r.ep0_eff;

endmodule

`default_nettype wire

/* testbench/udc_desc_props.sv */
// checker for the usb descriptor configuration block
`timescale 1ns/1ps
`default_nettype none

module udc_desc_props
    import udc_pkg::*;
(
    // clock and reset
    input wire logic clk, resetn,
    // register writes
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    // setup requests and answers
    input wire logic req_valid, req_status_done, req_std, req_hci_cmd, req_stall,
    input wire logic [7:0] req_type, req_code,
    input wire logic [15:0] req_value, req_index,
    // tokens, state, descriptor fields
    input wire logic tok_valid, tok_hit, tok_iface, tok_retry_ok, dp_pullup_en,
    input wire logic [6:0] tok_addr, dev_addr,
    input wire logic [1:0] tok_xfer,
    input wire logic [2:0] dev_state,
    input wire logic [7:0] desc_attributes, desc_ep0_size
);
    // ****
    // properties; dev_state[1] marks the default, addressed, configured states
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_set_addr;
        req_valid && req_type == 8'h00 && req_code == RQ_SET_ADDR && req_value != 16'h0000
            && dev_state == ST_DEFAULT ##1 req_std ##1 req_status_done;
    endsequence
    sequence s_class_req;
        req_valid && req_type[6:5] == 2'h1 && dev_state[1];
    endsequence
    a_set_address: assert property (s_set_addr |=> dev_addr == $past(req_value[6:0], 3)
        && dev_state == ST_ADDRESSED) else $error("address not applied after status");
    a_class_route: assert property (s_class_req |=> req_stall == !req_hci_cmd
        && req_hci_cmd == ($past(req_index[7:0]) == 8'h00)) else $error("class request misrouted");
    a_default_addr: assert property (dev_state == ST_DEFAULT |-> dev_addr == 7'h00)
        else $error("default state with nonzero address");
    a_tok_addr_match: assert property (tok_hit |-> $past(tok_valid)
        && $past(tok_addr) == $past(dev_addr)) else $error("token hit on foreign address");
    a_iface_map: assert property (tok_hit |-> tok_iface == (tok_xfer == XT_ISO))
        else $error("endpoint on wrong interface");
    a_iso_no_retry: assert property (tok_retry_ok == (tok_xfer != XT_ISO))
        else $error("retry flag wrong for transfer type");
    a_pullup_state: assert property (((dev_state == ST_DETACHED) |-> !dp_pullup_en)
        and (dev_state[1] |-> dp_pullup_en)) else $error("pull-up does not follow state");
    a_attr_fixed: assert property (desc_attributes[ATTR_RSVD1] && desc_attributes[4:0] == 5'h00)
        else $error("attribute fixed bits wrong");
    a_ep0_legal: assert property (desc_ep0_size inside {8'h08, 8'h10, 8'h20, 8'h40})
        else $error("illegal endpoint zero size");
    a_self_mirror: assert property (reg_wr && reg_addr == OFF_PWR |=>
        desc_attributes[ATTR_SELF] == $past(reg_wdata[0])) else $error("power key not mirrored");
    a_wake_mirror: assert property (reg_wr && reg_addr == OFF_WAKE |=>
        desc_attributes[ATTR_WAKE] == $past(reg_wdata[0])) else $error("wake key not mirrored");
endmodule

bind udc_desc_core udc_desc_props udc_desc_props_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .req_valid(req_valid),
    .req_status_done(req_status_done), .req_std(req_std), .req_hci_cmd(req_hci_cmd),
    .req_stall(req_stall), .req_type(req_type), .req_code(req_code), .req_value(req_value),
    .req_index(req_index), .tok_valid(tok_valid), .tok_hit(tok_hit), .tok_iface(tok_iface),
    .tok_retry_ok(tok_retry_ok), .dp_pullup_en(dp_pullup_en), .tok_addr(tok_addr),
    .dev_addr(dev_addr), .tok_xfer(tok_xfer), .dev_state(dev_state),
    .desc_attributes(desc_attributes), .desc_ep0_size(desc_ep0_size));
`default_nettype wire

/* testbench/udc_host_model.sv */
// hub and host model on the usb side of the descriptor block
`timescale 1ns/1ps
`default_nettype none

module udc_host_model
    import udc_pkg::*;
#(
    parameter int RST_DLY = 6
)
(
    // clock
    input wire logic clk,
    // line and bus reset
    input wire logic dp_pullup_en,
    output logic line_dp, line_dm, usb_bus_reset,
    // setup requests
    output logic req_valid, req_status_done,
    output logic [7:0] req_type, req_code,
    output logic [15:0] req_value, req_index,
    // tokens
    output logic tok_valid,
    output logic [6:0] tok_addr,
    output logic [3:0] tok_ep
);
    int cnt;
    logic dp_q;
    // pull-up gives idle j; released, the hub pull-down leaves both low
    assign line_dp = dp_pullup_en;
    assign line_dm = 1'b0;
    // quiet start
    initial begin
        {cnt, dp_q, usb_bus_reset, req_valid, req_status_done, tok_valid} = '0;
        {req_type, req_code, req_value, req_index, tok_addr, tok_ep} = '0;
    end
    // hub sees attach, host resets the port after a delay; detach stops it
    always @(posedge clk) begin
        dp_q <= line_dp;
        cnt <= (line_dp && !dp_q) ? RST_DLY + 4 : (cnt > 0 ? cnt - 1 : 0);
        usb_bus_reset <= line_dp && cnt > 0 && cnt <= 4;
    end
    // one setup packet; fields scrambled once the packet is gone
    task automatic setup(input logic [7:0] t, c, input logic [15:0] v, i);
        @(posedge clk);
        {req_type, req_code, req_value, req_index, req_valid} <= {t, c, v, i, 1'b1};
        @(posedge clk);
        {req_type, req_code, req_value, req_index, req_valid} <= {~t, ~c, ~v, ~i, 1'b0};
    endtask
    // status stage of the current control transfer
    task automatic status_stage();
        @(posedge clk);
        req_status_done <= 1'b1;
        @(posedge clk);
        req_status_done <= 1'b0;
    endtask
    // one token
    task automatic token(input logic [6:0] a, input logic [3:0] e);
        @(posedge clk);
        {tok_addr, tok_ep, tok_valid} <= {a, e, 1'b1};
        @(posedge clk);
        {tok_addr, tok_ep, tok_valid} <= {~a, ~e, 1'b0};
    endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking testbench of the usb descriptor configuration block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import udc_pkg::*;
    logic clk, resetn, reg_wr, reg_rd, line_dp, line_dm, usb_bus_reset, dp_pullup_en;
    logic req_valid, req_status_done, req_std, req_hci_cmd, req_stall, tok_valid, tok_hit;
    logic tok_iface, tok_retry_ok;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata, reg_rdata;
    logic [7:0] req_type, req_code, desc_i_maker, desc_i_product, desc_i_serial, desc_i_config;
    logic [7:0] desc_attributes, desc_ep0_size;
    logic [15:0] req_value, req_index, desc_bcd_usb, desc_vendor, desc_product, desc_lang_id;
    logic [23:0] desc_if0_class, desc_if1_class;
    logic [6:0] tok_addr, dev_addr;
    logic [3:0] tok_ep;
    logic [1:0] tok_xfer;
    logic [2:0] dev_state;
    int errors, total_checks;
    logic [11:0] ra[14] = '{OFF_SPEC, OFF_VID, OFF_PID, OFF_S_MAKER, OFF_S_PROD, OFF_S_SERIAL,
        OFF_S_CFG, OFF_ATTR, OFF_IF0, OFF_LANG, OFF_IF1, OFF_EP0, OFF_PWR, OFF_WAKE};
    logic [23:0] rv[14] = '{24'(RST_SPEC), 24'(RST_VID), 24'(RST_PID), 24'(RST_STR),
        24'(RST_STR), 24'(RST_STR), 24'(RST_STR), 24'(RST_ATTR), RST_IFC, 24'(RST_LANG),
        RST_IFC, 24'(RST_EP0), 24'h000001, 24'h000000};
    logic [7:0] sz[5] = '{8'h08, 8'h10, 8'h40, 8'h20, 8'h30};

    udc_desc_core udc_desc_core_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_dp(line_dp), .line_dm(line_dm), .usb_bus_reset(usb_bus_reset),
        .dp_pullup_en(dp_pullup_en), .req_valid(req_valid), .req_type(req_type),
        .req_code(req_code), .req_value(req_value), .req_index(req_index),
        .req_status_done(req_status_done), .req_std(req_std), .req_hci_cmd(req_hci_cmd),
        .req_stall(req_stall), .tok_valid(tok_valid), .tok_addr(tok_addr), .tok_ep(tok_ep),
        .tok_hit(tok_hit), .tok_xfer(tok_xfer), .tok_iface(tok_iface),
        .tok_retry_ok(tok_retry_ok), .dev_addr(dev_addr), .dev_state(dev_state),
        .desc_bcd_usb(desc_bcd_usb), .desc_vendor(desc_vendor), .desc_product(desc_product),
        .desc_i_maker(desc_i_maker), .desc_i_product(desc_i_product),
        .desc_i_serial(desc_i_serial), .desc_i_config(desc_i_config),
        .desc_attributes(desc_attributes), .desc_if0_class(desc_if0_class),
        .desc_if1_class(desc_if1_class), .desc_lang_id(desc_lang_id),
        .desc_ep0_size(desc_ep0_size));
    udc_host_model udc_host_model_inst (.clk(clk), .dp_pullup_en(dp_pullup_en),
        .line_dp(line_dp), .line_dm(line_dm), .usb_bus_reset(usb_bus_reset),
        .req_valid(req_valid), .req_status_done(req_status_done), .req_type(req_type),
        .req_code(req_code), .req_value(req_value), .req_index(req_index),
        .tok_valid(tok_valid), .tok_addr(tok_addr), .tok_ep(tok_ep));

    // ****
    // clock, compare and bus tasks
    // ****
    initial clk = 1'b0;
    always #50 clk = ~clk;
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [23:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [23:0] e);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, reg_rdata);
    endtask
    // token with expected {hit, xfer, iface, retry}
    task automatic tk(input logic [6:0] a, input logic [3:0] ep, input logic [4:0] e);
        udc_host_model_inst.token(a, ep);
        #1 chk("tok", 24'(e), 24'({tok_hit, tok_xfer, tok_iface, tok_retry_ok}));
    endtask
    // setup with expected {std, hci_cmd, stall}
    task automatic rq(input logic [7:0] t, c, input logic [15:0] v, i, input logic [2:0] e);
        udc_host_model_inst.setup(t, c, v, i);
        #1 chk("req", 24'(e), 24'({req_std, req_hci_cmd, req_stall}));
    endtask
    task automatic wait_state(input logic [2:0] e);
        for (int k = 0; k < 100 && !(dev_state === e && usb_bus_reset === 1'b0); k++)
            @(posedge clk);
        #1 chk("dev_state", 24'(e), 24'(dev_state));
        if (dev_state !== e) test_done();
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, errors, total_checks} = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 14; i++) rd(ra[i], rv[i]);
        wr(12'h2c6, 24'h00abcd);
        rd(12'h2c6, 24'h000000);
        chk("lang", 24'(RST_LANG), 24'(desc_lang_id));
        chk("attr", 24'h0000c0, 24'(desc_attributes));
        $display("test reset values done");
        wr(OFF_SPEC, 24'h000200);
        wr(OFF_VID, 24'h001234);
        wr(OFF_PID, 24'h005678);
        wr(OFF_S_MAKER, 24'h000001);
        wr(OFF_S_PROD, 24'h000002);
        wr(OFF_S_SERIAL, 24'h000003);
        wr(OFF_S_CFG, 24'h000004);
        wr(OFF_IF0, 24'hff0203);
        wr(OFF_IF1, 24'he00102);
        wr(OFF_LANG, 24'h000407);
        rd(OFF_IF1, 24'he00102);
        chk("bcd", 24'h000200, 24'(desc_bcd_usb));
        chk("ids", 24'h345678, {desc_vendor[7:0], desc_product});
        chk("strs", 24'h010203, {desc_i_maker, desc_i_product, desc_i_serial});
        chk("cfg_str", 24'h000004, 24'(desc_i_config));
        chk("if0", 24'hff0203, desc_if0_class);
        chk("if1", 24'he00102, desc_if1_class);
        chk("lang", 24'h000407, 24'(desc_lang_id));
        $display("test key fields done");
        wr(OFF_PWR, 24'h000000);
        rd(OFF_ATTR, 24'h000080);
        wr(OFF_WAKE, 24'h000001);
        rd(OFF_ATTR, 24'h0000a0);
        wr(OFF_ATTR, 24'h00005f);
        rd(OFF_PWR, 24'h000001);
        rd(OFF_WAKE, 24'h000000);
        rd(OFF_ATTR, 24'h0000c0);
        wr(OFF_ATTR, 24'h000020);
        rd(OFF_PWR, 24'h000000);
        rd(OFF_WAKE, 24'h000001);
        chk("attr", 24'h0000a0, 24'(desc_attributes));
        $display("test attribute mirrors done");
        for (int i = 0; i < 5; i++) begin
            wr(OFF_EP0, 24'(sz[i]));
            rd(OFF_EP0, 24'(sz[i]));
            chk("ep0", 24'(i == 4 ? 8'h40 : sz[i]), 24'(desc_ep0_size));
        end
        $display("test endpoint zero size done");
        wr(OFF_CTRL, 24'h000001);
        wait_state(ST_DEFAULT);
        rd(OFF_STAT, 24'h000403);
        tk(7'h00, 4'h0, 5'b1_00_0_1);
        tk(7'h00, 4'h1, 5'b0_11_0_1);
        rq(8'h00, RQ_SET_ADDR, 16'h0012, 16'h0000, 3'b100);
        udc_host_model_inst.status_stage();
        #1 chk("addr", 24'h000012, 24'(dev_addr));
        tk(7'h00, 4'h0, 5'b0_00_0_1);
        tk(7'h12, 4'h0, 5'b1_00_0_1);
        rq(8'h00, RQ_SET_CFG, 16'h0001, 16'h0000, 3'b100);
        udc_host_model_inst.status_stage();
        wait_state(ST_CONFIGURED);
        tk(7'h12, 4'h1, 5'b1_11_0_1);
        tk(7'h12, 4'h2, 5'b1_10_0_1);
        tk(7'h12, 4'h3, 5'b1_01_1_0);
        rq(8'h21, 8'h00, 16'h0000, 16'h0000, 3'b010);
        rq(8'h21, 8'h00, 16'h0000, 16'h0001, 3'b001);
        rq(8'h01, 8'h0b, 16'h0000, 16'h0001, 3'b100);
        $display("test enumeration done");
        wr(OFF_CTRL, 24'h000000);
        wait_state(ST_DETACHED);
        chk("lines", 24'h000000, 24'({dp_pullup_en, line_dp, line_dm, dev_addr}));
        rq(8'h00, RQ_SET_ADDR, 16'h0005, 16'h0000, 3'b000);
        $display("test detach done");
        test_done();
    end
endmodule
`default_nettype wire
